// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vac_pkg::*;
   logic clk, rst, hsel, hwrite, hready, hresp, we, nad, cide, shdn, rats, rate;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, sel, rx, tx;
   logic [2:0] hsize, md;
   logic [7:0] err, cnt, mdata, cidv;
   logic [15:0] maddr;
   logic [25:0] wq[$];
   int failures, compares;
   vac_host_model host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
      .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
   vac_apdu_ctrl dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .I_LAST_ERROR(err), .I_HELD_TARGET_COUNT(cnt),
      .I_RECEIVE_RATE_CODE(rx), .I_TRANSMIT_RATE_CODE(tx), .I_MODULATION_CODE(md), .O_MEM_WE(we),
      .O_MEM_SEL(sel), .O_MEM_ADDR(maddr), .O_MEM_DATA(mdata), .O_NODE_ADDRESS_USE_FLAG(nad),
      .O_CARD_IDENTIFIER_ENABLE(cide), .O_CARD_IDENTIFIER_VALUE(cidv), .O_CONTACT_READER_SHUTDOWN(shdn),
      .O_AUTO_ANSWER_SELECT_REQUEST(rats), .O_AUTO_RATE_NEGOTIATION_FLAG(rate));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (we === 1'b1) wq.push_back({sel, maddr, mdata});
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic send(input logic [111:0] v, input int n);
      logic [31:0] d;
      for (int i = 0; i < n; i++) host.xfer(1'b1, IDX_CMD_DATA, {24'h0, v[8*(n-1-i) +: 8]}, d);
   endtask
   task automatic rsp(input logic [55:0] v, input int n);
      logic [31:0] d;
      host.xfer(1'b0, IDX_STATUS, 32'h0, d);
      chk("bytes left", 32'(n), {29'h0, d[2:0]});
      for (int i = 0; i < n; i++) begin
         host.xfer(1'b0, IDX_RESP_DATA, 32'h0, d);
         chk("response byte", {23'h0, 1'b1, v[8*(n-1-i) +: 8]}, d);
      end
      host.xfer(1'b0, IDX_RESP_DATA, 32'h0, d);
      chk("response empty", 32'h0, d);
      chk("bus response", 32'h0, {31'h0, hresp});
   endtask
   task automatic flags(input logic [7:0] e);
      logic [31:0] d;
      chk("flag pins", {27'h0, e[5], e[4], e[3], e[1], e[0]}, {27'h0, rate, rats, shdn, cide, nad});
      host.xfer(1'b0, IDX_PARAM, 32'h0, d);
      chk("flag byte", {24'h0, e}, d);
   endtask
   task automatic t_write;
      wq.delete();
      send({8'hff, 8'he1, 8'h02, 8'h01, 8'h09, 8'h63, 8'h08, 8'h85, 8'hff, 8'he8, 8'h00, 8'ha0, 8'h20, 8'hda}, 14);
      rsp(56'h9000, 2);
      chk("write count", 32'h3, 32'(wq.size()));
      chk("xram write", {6'h0, SEL_XRAM, 16'h6308, 8'h85}, 32'(wq[0]));
      chk("sfr write", {6'h0, SEL_SFR, 16'h00e8, 8'h00}, 32'(wq[1]));
      chk("eeprom write", {6'h0, SEL_EEPROM, 16'h0020, 8'hda}, 32'(wq[2]));
      wq.delete();
      send({8'hff, 8'he1, 8'h02, 8'h01, 8'h06, 8'h03, 8'hc7, 8'h11, 8'h10, 8'h00, 8'h22}, 11);
      rsp(56'h6a82, 2);
      chk("mapped only", {5'h0, 1'b1, SEL_XRAM, 16'h03c7, 8'h11}, {5'h0, 1'(wq.size()), wq[0]});
      send({8'hff, 8'he1, 8'h02, 8'h01, 8'h04}, 5);
      rsp(56'h6700, 2);
   endtask
   task automatic t_param;
      logic [7:0] vals[6];
      vals = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h3b};
      wq.delete();
      foreach (vals[i]) begin
         send({8'hff, 8'he1, 8'h03, 8'h00, 8'h01, vals[i]}, 6);
         rsp(56'h9000, 2);
         flags(vals[i] & FLAG_MASK);
      end
      chk("no memory write", 32'h0, 32'(wq.size()));
   endtask
   task automatic t_status;
      logic [31:0] d;
      for (int k = 0; k < 8; k++) begin
         err <= 8'h50 + 8'(k);
         cnt <= {7'h0, k[0]};
         rx <= k[1:0];
         tx <= ~k[1:0];
         md <= k[2:0];
         send({8'hff, 8'he1, 8'h03, 8'h01, 8'h05}, 5);
         rsp({8'h50 + 8'(k), 7'h0, k[0], 6'h0, k[1:0], 6'h0, ~k[1:0], 5'h0, k[2:0], 16'h9000}, 7);
      end
      send({8'hff, 8'he1, 8'h03, 8'h01, 8'h04}, 5);
      rsp(56'h6700, 2);
      send({8'h00, 8'he1, 8'h03, 8'h01, 8'h05}, 5);
      rsp(56'h6e00, 2);
      send({8'hff, 8'he1, 8'h04, 8'h00, 8'h01}, 5);
      rsp(56'h6a86, 2);
      send({8'hff, 8'he1, 8'h03}, 3);
      host.xfer(1'b0, IDX_STATUS, 32'h0, d);
      chk("busy flag", 32'h1, {31'h0, d[STAT_BUSY_BIT]});
      host.xfer(1'b1, IDX_STATUS, 32'h1, d);
      send({8'hff, 8'he1, 8'h03, 8'h01, 8'h05}, 5);
      rsp({8'h57, 8'h01, 8'h03, 8'h00, 8'h07, 16'h9000}, 7);
   endtask
   task automatic end_of_test;
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      {err, cnt, rx, tx, md} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      flags(FLAG_RESET);
      chk("cid value", {24'h0, CID_FIXED}, {24'h0, cidv});
      t_write();
      t_param();
      t_status();
      end_of_test();
   end
endmodule
`default_nettype wire

// ### dv/vac_apdu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vac_apdu_monitor
   import vac_pkg::*;
(
   // Clock, reset and bus
   input wire logic        I_SYS_CLK,
   input wire logic        I_RESET,
   input wire logic        I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0]  I_HTRANS,
   input wire logic        I_HWRITE,
   input wire logic        I_HREADY,
   // Watched outputs
   input wire logic        O_MEM_WE,
   input wire logic [1:0]  O_MEM_SEL,
   input wire logic [15:0] O_MEM_ADDR,
   input wire logic [7:0]  O_CARD_IDENTIFIER_VALUE,
   input wire logic        O_CONTACT_READER_SHUTDOWN
);
   logic wr_dp;
   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wr_dp <= 1'b0;
      end else begin
         wr_dp <= I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE & (I_HADDR[7:2] == IDX_CMD_DATA);
      end
   end
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RESET);
   a_we_one_cycle: assert property (O_MEM_WE |=> !O_MEM_WE)
      else $error("memory write strobe longer than one cycle");
   a_we_from_cmd: assert property ($rose(O_MEM_WE) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("memory write without a command byte");
   a_we_has_target: assert property (O_MEM_WE |-> O_MEM_SEL != SEL_NONE)
      else $error("memory write with no target");
   a_xram_range: assert property (O_MEM_WE && O_MEM_SEL == SEL_XRAM |->
      O_MEM_ADDR <= XRAM_HI || O_MEM_ADDR[15:8] == XREG_HB)
      else $error("xram write outside its range");
   a_eeprom_low: assert property (O_MEM_WE && O_MEM_SEL == SEL_EEPROM |-> O_MEM_ADDR[15:8] == 8'h00)
      else $error("eeprom offset wider than a byte");
   a_sfr_upper: assert property (O_MEM_WE && O_MEM_SEL == SEL_SFR |-> O_MEM_ADDR[15:7] == 9'h001)
      else $error("sfr address outside upper half");
   a_cid_fixed: assert property (O_CARD_IDENTIFIER_VALUE == CID_FIXED)
      else $error("card identifier value not fixed");
   a_shdn_by_cmd: assert property ($changed(O_CONTACT_READER_SHUTDOWN) |-> $past(wr_dp) || $past(wr_dp, 2))
      else $error("shutdown pin moved without a command");
   c_xram: cover property (O_MEM_WE && O_MEM_SEL == SEL_XRAM);
   c_eeprom: cover property (O_MEM_WE && O_MEM_SEL == SEL_EEPROM);
   c_sfr: cover property (O_MEM_WE && O_MEM_SEL == SEL_SFR);
endmodule
bind vac_apdu_ctrl vac_apdu_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_HSEL(I_HSEL),
   .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .O_MEM_WE(O_MEM_WE),
   .O_MEM_SEL(O_MEM_SEL), .O_MEM_ADDR(O_MEM_ADDR), .O_CARD_IDENTIFIER_VALUE(O_CARD_IDENTIFIER_VALUE),
   .O_CONTACT_READER_SHUTDOWN(O_CONTACT_READER_SHUTDOWN));
`default_nettype wire

// ### dv/vac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vac_host_model (
   // Bus inputs
   input  wire logic        i_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   // Bus outputs
   output var  logic        o_hsel,
   output var  logic [31:0] o_haddr,
   output var  logic [1:0]  o_htrans,
   output var  logic        o_hwrite,
   output var  logic [2:0]  o_hsize,
   output var  logic [31:0] o_hwdata
);
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = 3'h2;
      o_hwdata = 32'h0;
   end
   // One single word transfer; bytes go out in order, reserved flag bits as given by caller
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      o_hsel <= 1'b1;
      o_htrans <= 2'h2;
      o_haddr <= {24'h0, idx, 2'h0};
      o_hwrite <= wr;
      do begin @(posedge i_clk); n++; end while (i_hready !== 1'b1 && n < 50);
      o_htrans <= 2'h0;
      o_hsel <= 1'b0;
      o_hwdata <= wr ? wd : ~o_hwdata;
      do begin @(posedge i_clk); n++; end while (i_hready !== 1'b1 && n < 100);
      rd = i_hrdata;
      if (n >= 50) begin
         tb.failures++;
         tb.end_of_test();
      end
   endtask
endmodule
`default_nettype wire

// ### verilog/vac_apdu_ctrl.sv
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vac_apdu_ctrl (
   // Clock and reset
   input  wire  logic        I_SYS_CLK,
   input  wire  logic        I_RESET,
   // AHB-Lite slave
   input  wire  logic        I_HSEL,
   input  wire  logic [31:0] I_HADDR,
   input  wire  logic [1:0]  I_HTRANS,
   input  wire  logic        I_HWRITE,
   input  wire  logic [2:0]  I_HSIZE,
   input  wire  logic [31:0] I_HWDATA,
   input  wire  logic        I_HREADY,
   output logic        [31:0] O_HRDATA,
   output logic               O_HREADYOUT,
   output logic               O_HRESP,
   // Device status sources
   input  wire  logic [7:0]  I_LAST_ERROR,
   input  wire  logic [7:0]  I_HELD_TARGET_COUNT,
   input  wire  logic [1:0]  I_RECEIVE_RATE_CODE,
   input  wire  logic [1:0]  I_TRANSMIT_RATE_CODE,
   input  wire  logic [2:0]  I_MODULATION_CODE,
   // Memory write port
   output logic               O_MEM_WE,
   output logic        [1:0]  O_MEM_SEL,
   output logic        [15:0] O_MEM_ADDR,
   output logic        [7:0]  O_MEM_DATA,
   // Behaviour flags
   output logic               O_NODE_ADDRESS_USE_FLAG,
   output logic               O_CARD_IDENTIFIER_ENABLE,
   output logic        [7:0]  O_CARD_IDENTIFIER_VALUE,
   output logic               O_CONTACT_READER_SHUTDOWN,
   output logic               O_AUTO_ANSWER_SELECT_REQUEST,
   output logic               O_AUTO_RATE_NEGOTIATION_FLAG
);
   import vac_pkg::*;

   vac_regs_t r_reg;
   vac_regs_t r_next;
   logic      addr_phase;

   // Address decode of the memory write target, used by writes only
   function automatic logic [1:0] addr_sel(input logic [15:0] a);
      if (a >= XRAM_LO && a <= XRAM_HI) begin
         return SEL_XRAM;
      end
      if (a[15:8] == XREG_HB) begin
         return SEL_XRAM;
      end
      if (a[15:8] == EEPROM_HB) begin
         return SEL_EEPROM;
      end
      if (a[15:8] == SFR_HB && a[7:0] >= SFR_LO) begin
         return SEL_SFR;
      end
      return SEL_NONE;
   endfunction

   function automatic logic is_mult3(input logic [7:0] v);
      return (v % ENTRY_BYTES) == 8'h00;
   endfunction

   // Load a bare status word as the response
   function automatic vac_regs_t with_sw(input vac_regs_t s, input logic [15:0] sw);
      vac_regs_t t;
      t = s;
      t.resp[0] = sw[15:8];
      t.resp[1] = sw[7:0];
      t.resp_len = 3'h2;
      t.resp_rd = 3'h0;
      t.state = ST_HDR;
      return t;
   endfunction

   assign addr_phase = I_HSEL & I_HTRANS[1] & I_HREADY;

   always_comb begin
      logic [7:0]  b;
      logic [15:0] adr;
      logic [1:0]  sel;
      b = I_HWDATA[7:0];
      adr = {r_reg.adr_hi, r_reg.adr_lo};
      sel = addr_sel(adr);
      r_next = r_reg;
      r_next.mem_we = 1'b0;

      // Address phase: latch write target, prepare read data
      r_next.dp_wr = addr_phase & I_HWRITE;
      if (addr_phase) begin
         r_next.dp_idx = I_HADDR[7:2];
      end
      if (addr_phase && !I_HWRITE) begin
         case (I_HADDR[7:2])
            IDX_RESP_DATA: begin
               r_next.rdata = 32'h0;
               if (r_reg.resp_rd < r_reg.resp_len) begin
                  r_next.rdata[7:0] = r_reg.resp[r_reg.resp_rd];
                  r_next.rdata[RESP_VALID_BIT] = 1'b1;
                  r_next.resp_rd = r_reg.resp_rd + 3'h1;
               end
            end
            IDX_STATUS: begin
               r_next.rdata = 32'h0;
               r_next.rdata[STAT_LEFT_LSB +: 3] = r_reg.resp_len - r_reg.resp_rd;
               r_next.rdata[STAT_BUSY_BIT] = (r_reg.state == ST_DATA) || (r_reg.hdr_idx != 3'h0);
            end
            IDX_PARAM: begin
               r_next.rdata = {24'h0, r_reg.flags};
            end
            default: begin
               r_next.rdata = 32'h0;
            end
         endcase
      end

      // Data phase of a write
      if (r_reg.dp_wr && r_reg.dp_idx == IDX_STATUS && I_HWDATA[0]) begin
         r_next.state = ST_HDR;
         r_next.hdr_idx = 3'h0;
         r_next.resp_len = 3'h0;
         r_next.resp_rd = 3'h0;
      end
      if (r_reg.dp_wr && r_reg.dp_idx == IDX_CMD_DATA) begin
         case (r_reg.state)
            ST_HDR: begin
               r_next.hdr_idx = r_reg.hdr_idx + 3'h1;
               case (r_reg.hdr_idx)
                  3'h0: begin
                     r_next.cla = b;
                     r_next.resp_len = 3'h0;
                     r_next.resp_rd = 3'h0;
                  end
                  3'h1: begin
                     r_next.ins = b;
                  end
                  3'h2: begin
                     r_next.p1 = b;
                  end
                  3'h3: begin
                     r_next.p2 = b;
                  end
                  default: begin
                     r_next.hdr_idx = 3'h0;
                     r_next.remain = b;
                     r_next.ent_idx = 2'h0;
                     r_next.bad_addr = 1'b0;
                     if (r_reg.cla != CLA_VENDOR) begin
                        r_next = with_sw(r_next, SW_BAD_CLA);
                     end else if (r_reg.ins != INS_VENDOR) begin
                        r_next = with_sw(r_next, SW_BAD_INS);
                     end else if (r_reg.p1 == P1_REGISTER && r_reg.p2 == P2_WRITE) begin
                        if (b == 8'h00 || !is_mult3(b)) begin
                           r_next = with_sw(r_next, SW_BAD_LEN);
                        end else begin
                           r_next.state = ST_DATA;
                        end
                     end else if (r_reg.p1 == P1_PARAM && r_reg.p2 == P2_SETPARAM) begin
                        if (b != LEN_PARAM) begin
                           r_next = with_sw(r_next, SW_BAD_LEN);
                        end else begin
                           r_next.state = ST_DATA;
                        end
                     end else if (r_reg.p1 == P1_PARAM && r_reg.p2 == P2_STATUS) begin
                        if (b != LEN_STATUS) begin
                           r_next = with_sw(r_next, SW_BAD_LEN);
                        end else begin
                           r_next.resp[0] = I_LAST_ERROR;
                           r_next.resp[1] = I_HELD_TARGET_COUNT;
                           r_next.resp[2] = {6'h0, I_RECEIVE_RATE_CODE};
                           r_next.resp[3] = {6'h0, I_TRANSMIT_RATE_CODE};
                           r_next.resp[4] = {5'h0, I_MODULATION_CODE};
                           r_next.resp[5] = SW_OK[15:8];
                           r_next.resp[6] = SW_OK[7:0];
                           r_next.resp_len = RESP_MAX;
                           r_next.resp_rd = 3'h0;
                        end
                     end else begin
                        r_next = with_sw(r_next, SW_BAD_P1P2);
                     end
                  end
               endcase
            end
            ST_DATA: begin
               if (r_reg.p1 == P1_PARAM) begin
                  r_next.flags = b & FLAG_MASK;
                  r_next = with_sw(r_next, SW_OK);
               end else begin
                  r_next.remain = r_reg.remain - 8'h01;
                  case (r_reg.ent_idx)
                     2'h0: begin
                        r_next.adr_hi = b;
                        r_next.ent_idx = 2'h1;
                     end
                     2'h1: begin
                        r_next.adr_lo = b;
                        r_next.ent_idx = 2'h2;
                     end
                     default: begin
                        r_next.ent_idx = 2'h0;
                        if (sel == SEL_NONE) begin
                           r_next.bad_addr = 1'b1;
                        end else begin
                           r_next.mem_we = 1'b1;
                           r_next.mem_sel = sel;
                           r_next.mem_data = b;
                           if (sel == SEL_XRAM) begin
                              r_next.mem_addr = adr;
                           end else begin
                              r_next.mem_addr = {8'h00, r_reg.adr_lo};
                           end
                        end
                     end
                  endcase
                  if (r_reg.remain == 8'h01) begin
                     if (r_next.bad_addr) begin
                        r_next = with_sw(r_next, SW_BAD_ADDR);
                     end else begin
                        r_next = with_sw(r_next, SW_OK);
                     end
                  end
               end
            end
            default: begin
               r_next.state = ST_HDR;
               r_next.hdr_idx = 3'h0;
            end
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         r_reg <= '0;
         r_reg.state <= ST_HDR;
         r_reg.flags <= FLAG_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign O_HRDATA = r_reg.rdata;
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP = 1'b0;
   assign O_MEM_WE = r_reg.mem_we;
   assign O_MEM_SEL = r_reg.mem_sel;
   assign O_MEM_ADDR = r_reg.mem_addr;
   assign O_MEM_DATA = r_reg.mem_data;
   assign O_NODE_ADDRESS_USE_FLAG = r_reg.flags[FLAG_NAD];
   assign O_CARD_IDENTIFIER_ENABLE = r_reg.flags[FLAG_CID];
   assign O_CARD_IDENTIFIER_VALUE = CID_FIXED;
   assign O_CONTACT_READER_SHUTDOWN = r_reg.flags[FLAG_SHDN];
   assign O_AUTO_ANSWER_SELECT_REQUEST = r_reg.flags[FLAG_RATS];
   assign O_AUTO_RATE_NEGOTIATION_FLAG = r_reg.flags[FLAG_RATE];
endmodule
`default_nettype wire

// ### verilog/vac_pkg.sv
package vac_pkg;
   // Register word indices (byte address = index * 4)
   localparam logic [5:0] IDX_CMD_DATA  = 6'h00;
   localparam logic [5:0] IDX_RESP_DATA = 6'h01;
   localparam logic [5:0] IDX_STATUS    = 6'h02;
   localparam logic [5:0] IDX_PARAM     = 6'h03;
   // Status register and response data register fields
   localparam int STAT_LEFT_LSB = 0;
   localparam int STAT_BUSY_BIT = 8;
   localparam int RESP_VALID_BIT = 8;
   // Command header codes
   localparam logic [7:0] CLA_VENDOR  = 8'hff;
   localparam logic [7:0] INS_VENDOR  = 8'he1;
   localparam logic [7:0] P1_REGISTER = 8'h02;
   localparam logic [7:0] P2_WRITE    = 8'h01;
   localparam logic [7:0] P1_PARAM    = 8'h03;
   localparam logic [7:0] P2_SETPARAM = 8'h00;
   localparam logic [7:0] P2_STATUS   = 8'h01;
   localparam logic [7:0] LEN_PARAM   = 8'h01;
   localparam logic [7:0] LEN_STATUS  = 8'h05;
   localparam logic [7:0] ENTRY_BYTES = 8'h03;
   localparam logic [2:0] HDR_LAST    = 3'h4;
   // Status words
   localparam logic [15:0] SW_OK       = 16'h9000;
   localparam logic [15:0] SW_BAD_LEN  = 16'h6700;
   localparam logic [15:0] SW_BAD_ADDR = 16'h6a82;
   localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
   localparam logic [15:0] SW_BAD_INS  = 16'h6d00;
   localparam logic [15:0] SW_BAD_CLA  = 16'h6e00;
   // Address map
   localparam logic [15:0] XRAM_LO   = 16'h0000;
   localparam logic [15:0] XRAM_HI   = 16'h03c7;
   // Page of the XRAM-mapped hardware registers, reached by full address
   localparam logic [7:0]  XREG_HB   = 8'h63;
   localparam logic [7:0]  EEPROM_HB = 8'ha0;
   localparam logic [7:0]  SFR_HB    = 8'hff;
   localparam logic [7:0]  SFR_LO    = 8'h80;
   localparam logic [1:0]  SEL_NONE   = 2'h0;
   localparam logic [1:0]  SEL_XRAM   = 2'h1;
   localparam logic [1:0]  SEL_EEPROM = 2'h2;
   localparam logic [1:0]  SEL_SFR    = 2'h3;
   // Flag byte
   localparam logic [7:0] FLAG_MASK  = 8'h3b;
   localparam logic [7:0] FLAG_RESET = 8'h30;
   localparam int FLAG_NAD  = 0;
   localparam int FLAG_CID  = 1;
   localparam int FLAG_SHDN = 3;
   localparam int FLAG_RATS = 4;
   localparam int FLAG_RATE = 5;
   localparam logic [7:0] CID_FIXED = 8'h01;
   localparam logic [2:0] RESP_MAX  = 3'h7;

   typedef enum logic [1:0] {
      ST_HDR  = 2'b01,
      ST_DATA = 2'b10
   } vac_state_t;

   typedef struct packed {
      vac_state_t      state;
      logic [2:0]      hdr_idx;
      logic [7:0]      cla;
      logic [7:0]      ins;
      logic [7:0]      p1;
      logic [7:0]      p2;
      logic [7:0]      remain;
      logic [1:0]      ent_idx;
      logic [7:0]      adr_hi;
      logic [7:0]      adr_lo;
      logic            bad_addr;
      logic [7:0]      flags;
      logic [6:0][7:0] resp;
      logic [2:0]      resp_len;
      logic [2:0]      resp_rd;
      logic            dp_wr;
      logic [5:0]      dp_idx;
      logic [31:0]     rdata;
      logic            mem_we;
      logic [1:0]      mem_sel;
      logic [15:0]     mem_addr;
      logic [7:0]      mem_data;
   } vac_regs_t;
endpackage
